// ==== src/lld_pkg.sv ====
// Shared constants and types for both ends of the low-latency DRAM port link.
// Assumes one system clock at 10 MHz on each end and a link clock made by the controller end.
package lld_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int LINK_PERIOD_NS = 800;
    localparam int LINK_PHASES = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINK_HALF = LINK_PHASES / 2;
    localparam int LINK_QUARTER = LINK_PHASES / 4;
    localparam int ADDR_W = 21;
    localparam int BANK_W = 3;
    localparam int LANE_W = 9;
    localparam int DATA_W_MAX = 18;
    localparam int EXP_BIT = 20;
    localparam int MEM_AW = 6;
    localparam int BURST = 2;
    localparam int REF_CYCLES = 16;
    localparam int FIFO_DEPTH = 32;
    localparam logic [ADDR_W-1:0] MODE_RESET = 21'h0;

    // Encoding is {write_cmd_n, refresh_cmd_n}, valid only while chip select is low.
    typedef enum logic [1:0] {
        CMD_MODE_SET = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_REFRESH = 2'h2,
        CMD_READ = 2'h3
    } lld_cmd_t;
endpackage : lld_pkg

// ==== src/lld_link_if.sv ====
// Pin-level link between the memory controller end and the DRAM device end.
// Assumes both ends share nothing but these wires; the bench joins them.
`timescale 1ns/1ps
interface lld_link_if;
    import lld_pkg::*;
    logic cmd_clock_p;
    logic cmd_clock_n;
    logic cs_n;
    logic write_cmd_n;
    logic refresh_cmd_n;
    logic [ADDR_W-1:0] addr_in;
    logic [BANK_W-1:0] bank_sel;
    logic input_data_clock_p;
    logic input_data_clock_n;
    logic [DATA_W_MAX-1:0] write_data_in;
    logic write_mask;
    logic [DATA_W_MAX-1:0] read_data_out;
    logic [1:0] output_data_clock_p;
    logic [1:0] output_data_clock_n;
    logic read_valid;

    modport ctrl (
        output cmd_clock_p, cmd_clock_n, cs_n, write_cmd_n, refresh_cmd_n, addr_in, bank_sel,
        output input_data_clock_p, input_data_clock_n, write_data_in, write_mask,
        input read_data_out, output_data_clock_p, output_data_clock_n, read_valid
    );
    modport dev (
        input cmd_clock_p, cmd_clock_n, cs_n, write_cmd_n, refresh_cmd_n, addr_in, bank_sel,
        input input_data_clock_p, input_data_clock_n, write_data_in, write_mask,
        output read_data_out, output_data_clock_p, output_data_clock_n, read_valid
    );
endinterface : lld_link_if

// ==== src/lld_dev_end.sv ====
// Device end of the low-latency DRAM port: command decode, small storage array, DDR data paths.
// Assumes every link input is asynchronous to clk and runs far slower than clk.
`timescale 1ns/1ps
module lld_dev_end #(
    parameter int DATA_W = 18,
    parameter int REF_LEN = 16
) (
    input wire logic clk,
    input wire logic rst,
    lld_link_if.dev link,
    output logic [lld_pkg::ADDR_W-1:0] mode_cfg,
    output logic refresh_busy
);
    import lld_pkg::*;

    localparam int LANES = DATA_W / LANE_W;
    localparam int SW = 7 + BANK_W + ADDR_W + DATA_W + 1;
    localparam int IDX_W = BANK_W + MEM_AW + 1;
    localparam int QC_W = $clog2(LINK_HALF);
    localparam int RC_W = $clog2(REF_LEN + 1);

    generate
        if (DATA_W != LANE_W && DATA_W != DATA_W_MAX) begin : g_bad_width
            $error("lld_dev_end: DATA_W must be 9 or 18");
        end
        if (REF_LEN < 1) begin : g_bad_ref
            $error("lld_dev_end: REF_LEN must be at least 1");
        end
    endgenerate

    // Two-stage synchroniser for every link input; only stage two is read by logic.
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic cclk_prev;
    logic dclk_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {link.cmd_clock_p, link.cmd_clock_n, link.input_data_clock_p, link.input_data_clock_n,
                      link.cs_n, link.write_cmd_n, link.refresh_cmd_n, link.bank_sel, link.addr_in,
                      link.write_data_in[DATA_W-1:0], link.write_mask};
            sync2 <= sync1;
        end
    end

    logic cclk_p;
    logic cclk_n;
    logic dclk_p;
    logic dclk_n;
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wmask;

    assign {cclk_p, cclk_n, dclk_p, dclk_n, cs_n, we_n, ref_n, bank, addr, wdata, wmask} = sync2;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cclk_prev <= 1'b0;
            dclk_prev <= 1'b0;
        end else begin
            cclk_prev <= cclk_p;
            dclk_prev <= dclk_p;
        end
    end

    // A rise counts only when the complementary leg has swung the other way.
    logic cclk_rise;
    logic dclk_rise;
    logic dclk_fall;
    assign cclk_rise = cclk_p & ~cclk_prev & ~cclk_n;
    assign dclk_rise = dclk_p & ~dclk_prev & ~dclk_n;
    assign dclk_fall = ~dclk_p & dclk_prev & dclk_n;

    logic cmd_take;
    lld_cmd_t cmd;
    logic [ADDR_W-1:0] eff_addr;
    logic [BANK_W+MEM_AW-1:0] base;

    assign cmd_take = cclk_rise & ~cs_n;
    assign cmd = lld_cmd_t'({we_n, ref_n});
    // The expansion bit is forced to zero only when DATA_W is 18; with DATA_W of 9 it passes into eff_addr and mode_cfg.
    assign eff_addr = (DATA_W == DATA_W_MAX) ? (addr & ~(21'h1 << EXP_BIT)) : addr;
    assign base = {bank, eff_addr[MEM_AW-1:0]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_cfg <= MODE_RESET;
        end else if (cmd_take && cmd == CMD_MODE_SET) begin
            mode_cfg <= eff_addr;
        end
    end

    // Refresh runs to its end regardless of chip select.
    logic [RC_W-1:0] ref_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt <= '0;
            refresh_busy <= 1'b0;
        end else if (cmd_take && cmd == CMD_REFRESH && ref_cnt == '0) begin
            ref_cnt <= RC_W'(REF_LEN);
            refresh_busy <= 1'b1;
        end else if (ref_cnt != '0) begin
            ref_cnt <= ref_cnt - 1'b1;
            refresh_busy <= (ref_cnt != RC_W'(1));
        end
    end

    // Storage is a small window of the real array: bank, low address bits, beat.
    logic [DATA_W-1:0] mem [2**IDX_W];

    logic wr_arm;
    logic wr_b1;
    logic [BANK_W+MEM_AW-1:0] wr_base;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_arm <= 1'b0;
            wr_b1 <= 1'b0;
            wr_base <= '0;
        end else begin
            if (dclk_fall && wr_arm) begin
                wr_arm <= 1'b0;
                wr_b1 <= 1'b1;
            end
            if (dclk_rise && wr_b1) begin
                wr_b1 <= 1'b0;
            end
            if (cmd_take && cmd == CMD_WRITE) begin
                wr_arm <= 1'b1;
                wr_base <= base;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (dclk_fall && wr_arm && !wmask) begin
            mem[{wr_base, 1'b0}] <= wdata;
        end else if (dclk_rise && wr_b1 && !wmask) begin
            mem[{wr_base, 1'b1}] <= wdata;
        end
    end

    // Output clock divider never stops, so the controller can train on it at any time.
    logic [QC_W-1:0] oclk_cnt;
    logic oclk_tick;
    logic oclk_phase;
    assign oclk_tick = (oclk_cnt == QC_W'(LINK_HALF - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oclk_cnt <= '0;
            oclk_phase <= 1'b0;
        end else begin
            oclk_cnt <= oclk_tick ? '0 : oclk_cnt + 1'b1;
            if (oclk_tick) begin
                oclk_phase <= ~oclk_phase;
            end
        end
    end

    logic rd_pend;
    logic rd_b1;
    logic [BANK_W+MEM_AW-1:0] rd_base;
    logic [BANK_W+MEM_AW-1:0] rd_cur;

    // A read arriving in the cycle its predecessor leaves the pending slot still pends.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pend <= 1'b0;
            rd_b1 <= 1'b0;
            rd_base <= '0;
            rd_cur <= '0;
        end else begin
            if (oclk_tick) begin
                if (rd_b1) begin
                    rd_b1 <= 1'b0;
                end else if (rd_pend) begin
                    rd_cur <= rd_base;
                    rd_b1 <= 1'b1;
                    rd_pend <= 1'b0;
                end
            end
            if (cmd_take && cmd == CMD_READ) begin
                rd_pend <= 1'b1;
                rd_base <= base;
            end
        end
    end

    // Clocks, data and valid all change in the same clk cycle, giving edge alignment.
    logic [DATA_W_MAX-1:0] q_out;
    logic [1:0] oclk_p;
    logic [1:0] oclk_n;
    logic q_valid;

    genvar l;
    generate
        for (l = 0; l < 2; l++) begin : g_lane
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    oclk_p[l] <= 1'b0;
                    oclk_n[l] <= 1'b1;
                    q_out[l*LANE_W +: LANE_W] <= '0;
                end else if (l < LANES) begin
                    oclk_p[l] <= oclk_tick ? ~oclk_phase : oclk_phase;
                    oclk_n[l] <= oclk_tick ? oclk_phase : ~oclk_phase;
                    if (oclk_tick) begin
                        q_out[l*LANE_W +: LANE_W] <= next_lane(l);
                    end
                end
            end
        end
    endgenerate

    function automatic logic [LANE_W-1:0] next_lane(input int lane);
        logic [DATA_W-1:0] w;
        w = '0;
        if (rd_b1) begin
            w = mem[{rd_cur, 1'b1}];
        end else if (rd_pend) begin
            w = mem[{rd_base, 1'b0}];
        end
        return w[lane*LANE_W +: LANE_W];
    endfunction : next_lane

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_valid <= 1'b0;
        end else if (oclk_tick) begin
            q_valid <= rd_b1 | rd_pend;
        end
    end

    assign link.read_data_out = q_out;
    assign link.output_data_clock_p = oclk_p;
    assign link.output_data_clock_n = oclk_n;
    assign link.read_valid = q_valid;
endmodule : lld_dev_end

// ==== src/lld_ctrl_end.sv ====
// Controller end: link clock divider, command issue, DDR write driver, per-lane read capture, read FIFO.
// Assumes the device end on the far side of the link runs on its own unrelated clock.
`timescale 1ns/1ps
module lld_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("lld_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic push;
    logic pop;
    logic [CW-1:0] next_level;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign next_level = level + CW'(push) - CW'(pop);
    assign out_data = store[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + PW'(push);
            rd_ptr <= rd_ptr + PW'(pop);
            level <= next_level;
            in_ready <= (next_level != CW'(DEPTH));
            out_valid <= (next_level != '0);
        end
    end
endmodule : lld_fifo

module lld_ctrl_end #(
    parameter int DATA_W = 18,
    parameter int RD_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    lld_link_if.ctrl link,
    input wire logic req_valid,
    output logic req_ready,
    input wire lld_pkg::lld_cmd_t req_cmd,
    input wire logic [lld_pkg::BANK_W-1:0] req_bank,
    input wire logic [lld_pkg::ADDR_W-1:0] req_addr,
    input wire logic [2*DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_wmask,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [2*DATA_W-1:0] rsp_data
);
    import lld_pkg::*;

    localparam int LANES = DATA_W / LANE_W;
    localparam int PH_W = $clog2(LINK_PHASES);
    localparam int CW = $clog2(RD_DEPTH + 1);

    generate
        if (DATA_W != LANE_W && DATA_W != DATA_W_MAX) begin : g_bad_width
            $error("lld_ctrl_end: DATA_W must be 9 or 18");
        end
    endgenerate

    typedef enum logic [2:0] {
        WS_IDLE = 3'h1,
        WS_B0 = 3'h2,
        WS_B1 = 3'h4
    } lld_wstate_t;

    logic [PH_W-1:0] ph;
    logic link_clk;
    logic link_clk_n;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph <= '0;
            link_clk <= 1'b0;
            link_clk_n <= 1'b1;
        end else begin
            ph <= (ph == PH_W'(LINK_PHASES - 1)) ? '0 : ph + 1'b1;
            if (ph == PH_W'(LINK_PHASES - 1)) begin
                link_clk <= 1'b1;
                link_clk_n <= 1'b0;
            end else if (ph == PH_W'(LINK_HALF - 1)) begin
                link_clk <= 1'b0;
                link_clk_n <= 1'b1;
            end
        end
    end

    lld_wstate_t wstate;
    logic [CW-1:0] fifo_level;
    logic [CW-1:0] out_rd;
    logic take;
    logic push;
    logic credit_ok;

    // Reads are admitted only while the FIFO can hold every burst still in flight.
    assign credit_ok = (CW'(fifo_level + out_rd) < CW'(RD_DEPTH));
    assign take = req_valid & req_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (ph == PH_W'(LINK_HALF - 2)) && credit_ok && (wstate == WS_IDLE);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_rd <= '0;
        end else begin
            out_rd <= out_rd + CW'(take && req_cmd == CMD_READ) - CW'(push);
        end
    end

    // Command pins change on the falling link edge so the device sees them settled at the rise.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.cs_n <= 1'b1;
            link.write_cmd_n <= 1'b1;
            link.refresh_cmd_n <= 1'b1;
            link.addr_in <= '0;
            link.bank_sel <= '0;
        end else if (ph == PH_W'(LINK_HALF - 1)) begin
            link.cs_n <= ~take;
            if (take) begin
                {link.write_cmd_n, link.refresh_cmd_n} <= req_cmd;
                link.addr_in <= req_addr;
                link.bank_sel <= req_bank;
            end
        end
    end

    // Write beats change a quarter period away from each data clock edge.
    logic [2*DATA_W-1:0] wbuf;
    logic [1:0] mbuf;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wstate <= WS_IDLE;
            wbuf <= '0;
            mbuf <= '0;
            link.write_data_in <= '0;
            link.write_mask <= 1'b0;
        end else begin
            case (wstate)
                WS_IDLE: begin
                    if (take && req_cmd == CMD_WRITE) begin
                        wbuf <= req_wdata;
                        mbuf <= req_wmask;
                        wstate <= WS_B0;
                    end
                end
                WS_B0: begin
                    if (ph == PH_W'(LINK_QUARTER - 1)) begin
                        link.write_data_in[DATA_W-1:0] <= wbuf[DATA_W-1:0];
                        link.write_mask <= mbuf[0];
                        wstate <= WS_B1;
                    end
                end
                WS_B1: begin
                    if (ph == PH_W'(LINK_HALF + LINK_QUARTER - 1)) begin
                        link.write_data_in[DATA_W-1:0] <= wbuf[2*DATA_W-1:DATA_W];
                        link.write_mask <= mbuf[1];
                        wstate <= WS_IDLE;
                    end
                end
                default: wstate <= WS_IDLE;
            endcase
        end
    end

    assign link.cmd_clock_p = link_clk;
    assign link.cmd_clock_n = link_clk_n;
    assign link.input_data_clock_p = link_clk;
    assign link.input_data_clock_n = link_clk_n;

    // Read side: two-flop synchronisers, then edge detect on stage two only.
    logic [DATA_W_MAX+2:0] rs1;
    logic [DATA_W_MAX+2:0] rs2;
    logic [1:0] oclk_prev;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rs1 <= '0;
            rs2 <= '0;
            oclk_prev <= '0;
        end else begin
            rs1 <= {link.read_valid, link.output_data_clock_p, link.read_data_out};
            rs2 <= rs1;
            oclk_prev <= rs2[DATA_W_MAX+1:DATA_W_MAX];
        end
    end

    logic [LANE_W-1:0] beat0 [LANES];
    logic [LANE_W-1:0] beat1 [LANES];
    logic [LANES-1:0] bt;
    logic [LANES-1:0] done;
    logic [2*DATA_W-1:0] pair;

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            logic edge_seen;
            assign edge_seen = rs2[DATA_W_MAX+l] ^ oclk_prev[l];
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    beat0[l] <= '0;
                    beat1[l] <= '0;
                    bt[l] <= 1'b0;
                    done[l] <= 1'b0;
                end else begin
                    done[l] <= 1'b0;
                    if (edge_seen && !rs2[DATA_W_MAX+2]) begin
                        bt[l] <= 1'b0;
                    end else if (edge_seen && !bt[l]) begin
                        beat0[l] <= rs2[l*LANE_W +: LANE_W];
                        bt[l] <= 1'b1;
                    end else if (edge_seen) begin
                        beat1[l] <= rs2[l*LANE_W +: LANE_W];
                        bt[l] <= 1'b0;
                        done[l] <= 1'b1;
                    end
                end
            end
            assign pair[l*LANE_W +: LANE_W] = beat0[l];
            assign pair[DATA_W + l*LANE_W +: LANE_W] = beat1[l];
        end
    endgenerate

    logic fifo_in_ready;
    assign push = (&done) & fifo_in_ready;

    lld_fifo #(
        .WIDTH(2 * DATA_W),
        .DEPTH(RD_DEPTH)
    ) lld_fifo_inst (
        .clk(clk),
        .rst(rst),
        .in_valid(&done),
        .in_ready(fifo_in_ready),
        .in_data(pair),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data(rsp_data),
        .level(fifo_level)
    );
endmodule : lld_ctrl_end

// ==== sim/lld_link_assertions.sv ====
// Concurrent checks on the pin-level link between the controller end and the device end.
// Assumes the bench wires these inputs straight to the link interface signals.
`timescale 1ns/1ps
module lld_link_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_clock_p,
    input wire logic cmd_clock_n,
    input wire logic cs_n,
    input wire logic write_cmd_n,
    input wire logic [lld_pkg::ADDR_W-1:0] addr_in,
    input wire logic input_data_clock_p,
    input wire logic [lld_pkg::DATA_W_MAX-1:0] write_data_in,
    input wire logic write_mask,
    input wire logic [lld_pkg::DATA_W_MAX-1:0] read_data_out,
    input wire logic [1:0] output_data_clock_p,
    input wire logic [1:0] output_data_clock_n,
    input wire logic read_valid
);
    import lld_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_valid_start;
        $rose(read_valid);
    endsequence
    sequence s_two_beats;
        read_valid [*8];
    endsequence
    a_cmd_pair_opposite: assert property (cmd_clock_p != cmd_clock_n)
        else $error("command clock legs equal");
    a_dclk_follows_cclk: assert property (input_data_clock_p == cmd_clock_p)
        else $error("data clock departs from command clock");
    a_oclk_pairs_opposite: assert property (output_data_clock_p == ~output_data_clock_n)
        else $error("output clock legs equal");
    a_oclk_free_run: assert property (1'b1 |-> ##[1:5] $changed(output_data_clock_p[0]))
        else $error("output clock stopped");
    a_low_lane_edge: assert property ($changed(read_data_out[8:0]) |-> $changed(output_data_clock_p[0]))
        else $error("low lane data off its clock edge");
    a_high_lane_edge: assert property ($changed(read_data_out[17:9]) |-> $changed(output_data_clock_p[1]))
        else $error("upper lane data off its clock edge");
    a_valid_on_edge: assert property ($changed(read_valid) |-> $changed(output_data_clock_p[0]))
        else $error("read valid off clock edge");
    a_valid_two_beats: assert property (s_valid_start |-> s_two_beats)
        else $error("read valid shorter than two beats");
    a_cmd_stable_rise: assert property ($rose(cmd_clock_p) |-> $stable({cs_n, write_cmd_n, addr_in}))
        else $error("command pins move at clock rise");
    a_wdata_off_edge: assert property ($changed({write_data_in, write_mask}) |-> $stable(input_data_clock_p))
        else $error("write beat moves on data clock edge");
endmodule : lld_link_assertions

// ==== sim/test_low_latency_dram_port.sv ====
// Self-checking bench: controller end and device end joined over one link.
// Assumes one shared clk and rst; refresh length shortened to 4.
`timescale 1ns/1ps
module test_low_latency_dram_port;
    import lld_pkg::*;
    localparam logic [35:0] P1 = 36'h1_2345_6789;
    localparam logic [35:0] P2 = 36'h9_8765_4321;
    localparam logic [35:0] P3 = 36'h5_a5a5_a5a5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    lld_cmd_t req_cmd = CMD_READ;
    logic [BANK_W-1:0] req_bank = 3'h0;
    logic [ADDR_W-1:0] req_addr = 21'h0;
    logic [35:0] req_wdata = 36'h0;
    logic [1:0] req_wmask = 2'h0;
    logic rsp_valid;
    logic rsp_ready = 1'b0;
    logic [35:0] rsp_data;
    logic [ADDR_W-1:0] mode_cfg;
    logic refresh_busy;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    lld_link_if lld_link_if_inst ();
    lld_ctrl_end #(.DATA_W(18), .RD_DEPTH(32)) lld_ctrl_end_inst (.clk(clk), .rst(rst),
        .link(lld_link_if_inst.ctrl), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata), .req_wmask(req_wmask),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
    lld_dev_end #(.DATA_W(18), .REF_LEN(4)) lld_dev_end_inst (.clk(clk), .rst(rst),
        .link(lld_link_if_inst.dev), .mode_cfg(mode_cfg), .refresh_busy(refresh_busy));
    lld_link_assertions lld_link_assertions_inst (.clk(clk), .rst(rst),
        .cmd_clock_p(lld_link_if_inst.cmd_clock_p), .cmd_clock_n(lld_link_if_inst.cmd_clock_n),
        .cs_n(lld_link_if_inst.cs_n), .write_cmd_n(lld_link_if_inst.write_cmd_n),
        .addr_in(lld_link_if_inst.addr_in), .input_data_clock_p(lld_link_if_inst.input_data_clock_p),
        .write_data_in(lld_link_if_inst.write_data_in), .write_mask(lld_link_if_inst.write_mask),
        .read_data_out(lld_link_if_inst.read_data_out), .read_valid(lld_link_if_inst.read_valid),
        .output_data_clock_p(lld_link_if_inst.output_data_clock_p),
        .output_data_clock_n(lld_link_if_inst.output_data_clock_n));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check_word(input string what, input logic [35:0] exp, input logic [35:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // Holds the request through the edge at which req_ready is high, then lets one edge pass.
    task automatic issue(input lld_cmd_t c, input logic [2:0] b, input logic [20:0] a, input logic [35:0] d,
            input logic [1:0] m, output bit taken);
        int n;
        taken = 1'b0;
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        req_wdata = d;
        req_wmask = m;
        req_valid = 1'b1;
        for (n = 0; n < 40 && !taken; n++) begin
            taken = (req_ready === 1'b1);
            idle(1);
        end
        req_valid = 1'b0;
        idle(1);
    endtask : issue
    task automatic send(input lld_cmd_t c, input logic [2:0] b, input logic [20:0] a, input logic [35:0] d,
            input logic [1:0] m);
        bit t;
        issue(c, b, a, d, m, t);
        check_word("request taken", 36'h1, {35'h0, t});
    endtask : send
    task automatic pop(input logic [35:0] exp);
        int n;
        n = 0;
        do begin
            idle(1);
            n++;
        end while (rsp_valid !== 1'b1 && n < 80);
        check_word("rsp_valid", 36'h1, {35'h0, rsp_valid});
        check_word("rsp_data", exp, rsp_data);
        rsp_ready = 1'b1;
        idle(1);
        rsp_ready = 1'b0;
    endtask : pop
    task automatic scn_write_read();
        send(CMD_WRITE, 3'h5, 21'h12, P1, 2'h0);
        send(CMD_WRITE, 3'h2, 21'h12, P3, 2'h0);
        send(CMD_WRITE, 3'h5, 21'h12, P2, 2'h2);
        send(CMD_WRITE, 3'h2, 21'h12, P1, 2'h1);
        // Leaves the last write beats time to land before they are read back.
        idle(16);
        send(CMD_READ, 3'h5, 21'h10_0012, 36'h0, 2'h0);
        send(CMD_READ, 3'h2, 21'h12, 36'h0, 2'h0);
        pop({P1[35:18], P2[17:0]});
        pop({P1[35:18], P3[17:0]});
    endtask : scn_write_read
    task automatic scn_mode();
        send(CMD_MODE_SET, 3'h0, 21'h1a_5a5a, 36'h0, 2'h0);
        idle(24);
        check_word("mode_cfg", 36'h0a_5a5a, {15'h0, mode_cfg});
    endtask : scn_mode
    task automatic scn_refresh();
        int n;
        int len;
        send(CMD_REFRESH, 3'h1, 21'h0, 36'h0, 2'h0);
        for (n = 0; n < 40 && refresh_busy !== 1'b1; n++) begin
            idle(1);
        end
        for (len = 0; len < 40 && refresh_busy === 1'b1; len++) begin
            idle(1);
        end
        check_word("refresh length", 36'h4, 36'(len));
    endtask : scn_refresh
    // Reads pile up unpopped until the controller stops taking them, then all drain in order.
    task automatic scn_fifo();
        int k;
        bit t;
        k = 0;
        do begin
            issue(CMD_READ, 3'h2, 21'h12, 36'h0, 2'h0, t);
            k += int'(t);
        end while (t && k < 40);
        check_word("reads taken", 36'h20, 36'(k));
        repeat (32) pop({P1[35:18], P3[17:0]});
        idle(60);
        check_word("rsp_valid empty", 36'h0, {35'h0, rsp_valid});
    endtask : scn_fifo
    initial begin
        idle(20);
        rst = 1'b0;
        idle(4);
        scn_write_read();
        scn_mode();
        scn_refresh();
        scn_fifo();
        end_of_test();
    end
endmodule : test_low_latency_dram_port
